// *** logic/shsq_top.sv ***
// sector header voting and data sync qualifier with avalon register slave
//
// The Avalon-MM slave port was decided locally.
`timescale 1ns/10ps
`include "shsq_params.svh"

module shsq_top (
   input  wire logic                 i_clk,
   input  wire logic                 i_resetn,
   input  wire logic                 i_ce,
   input  wire logic [8:0]           i_avs_address,
   input  wire logic                 i_avs_read,
   input  wire logic                 i_avs_write,
   input  wire logic [31:0]          i_avs_writedata,
   output logic      [31:0]          o_avs_readdata,
   output logic                      o_avs_waitrequest,
   input  wire logic                 i_op_start,
   input  wire shsq_pkg::shsq_op_e   i_op_kind,
   input  wire logic                 i_op_end,
   input  wire logic                 i_sector_start,
   input  wire shsq_pkg::shsq_copy_s i_copy,
   input  wire logic                 i_hdr_end,
   input  wire logic                 i_data_start,
   input  wire logic                 i_sync_eval,
   input  wire logic [3:0]           i_sync_groups,
   output logic                      o_op_active,
   output logic                      o_sector_go,
   output logic                      o_sync_found,
   output logic                      o_byte_valid,
   output logic      [7:0]           o_byte_data,
   output logic                      o_resync_hunt,
   output logic                      o_irq
);

   // ----------------------------------------------------------------
   // declarations
   // ----------------------------------------------------------------
   logic                   wait_q;
   logic [31:0]            rdata_q;
   logic [7:0]             ctrl_q;
   logic [7:0]             skip_q;
   logic [7:0]             stat_q;
   logic [7:0]             stat_d;
   logic [`SHSQ_IRQ_W-1:0] irq_st_q;
   logic [`SHSQ_IRQ_W-1:0] irq_en_q;
   logic [`SHSQ_IRQ_W-1:0] irq_ev;
   logic                   irq_q;
   logic                   active_q;
   shsq_pkg::shsq_op_e     kind_q;
   logic [1:0]             cnt_q;
   logic [1:0]             cnt_d;
   logic                   seen_q;
   logic                   seen_d;
   logic                   done_q;
   logic                   done_d;
   logic                   go_d;
   logic                   go_q;
   logic                   thr_err;
   logic                   good;
   logic [2:0]             copy_bit;
   logic                   found_q;
   shsq_pkg::shsq_skip_e   sk_q;
   logic [7:0]             sk_cnt_q;
   logic                   bv_q;
   logic [7:0]             bd_q;
   logic                   hunt_q;
   logic [31:0]            rd_word;
   logic                   wr_acc;
   logic [6:0]             idx;
   logic                   skip_mode;
   logic [1:0]             vote;
   logic [3:0]             sthr;

   // ----------------------------------------------------------------
   // functions
   // ----------------------------------------------------------------
   // write strobe for one register index
   function automatic logic wr_hit(input logic acc, input logic [6:0] a, input logic [6:0] ix);
      wr_hit = acc && (a == ix);
   endfunction : wr_hit
   // copies needed: locate/fetch stop on the first good matching copy
   function automatic logic [1:0] need_copies(input shsq_pkg::shsq_op_e k,
                                              input logic [1:0] v);
      need_copies = (k == shsq_pkg::SHSQ_OP_OTHER) ? v : 2'h1;
   endfunction : need_copies
   // dummy bytes stand in for the data up to the chosen resync mark
   function automatic logic [7:0] dummy_total(input logic [1:0] s);
      dummy_total = 8'(`SHSQ_DUMMY_PER_MK * s);
   endfunction : dummy_total

   // ----------------------------------------------------------------
   // field views
   // ----------------------------------------------------------------
   assign vote      = ctrl_q[`SHSQ_VOTE_MSB:`SHSQ_VOTE_LSB];
   assign sthr      = ctrl_q[`SHSQ_STHR_MSB:`SHSQ_STHR_LSB];
   assign skip_mode = (sthr == 4'h0);
   assign idx       = i_avs_address[8:2];
   assign wr_acc    = i_avs_write && !wait_q;

   // ----------------------------------------------------------------
   // avalon slave: one wait cycle, read data latched with it
   // ----------------------------------------------------------------
   // waitrequest drops for exactly one cycle per request
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         wait_q <= 1'b1;
      end else if (i_ce) begin
         wait_q <= !((i_avs_read | i_avs_write) && wait_q);
      end
   end
   // read mux; unmapped and write-only indexes read zero
   always_comb begin
      rd_word = 32'h0;
      case (idx)
         `SHSQ_IDX_SKIP:     rd_word = {24'h0, skip_q};
         `SHSQ_IDX_CTRL:     rd_word = {24'h0, ctrl_q};
         `SHSQ_IDX_STAT:     rd_word = {24'h0, stat_q};
         `SHSQ_IDX_IRQ_STAT: rd_word = {27'h0, irq_st_q};
         `SHSQ_IDX_IRQ_EN:   rd_word = {27'h0, irq_en_q};
         default:            rd_word = 32'h0;
      endcase
   end
   // data captured when the request is first seen, stands while wait is low
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         rdata_q <= 32'h0;
      end else if (i_ce && i_avs_read && wait_q) begin
         rdata_q <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // software registers
   // ----------------------------------------------------------------
   // control and skip count; control changes take effect at once, the skip count is sampled only at data start
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q   <= `SHSQ_CTRL_RESET;
         skip_q   <= `SHSQ_SKIP_RESET;
         irq_en_q <= '0;
      end else if (i_ce) begin
         if (wr_hit(wr_acc, idx, `SHSQ_IDX_CTRL)) begin
            ctrl_q <= i_avs_writedata[7:0];
         end
         if (wr_hit(wr_acc, idx, `SHSQ_IDX_SKIP)) begin
            skip_q <= {2'h0, i_avs_writedata[`SHSQ_SKIP_MSB:`SHSQ_SKIP_LSB], 4'h0};
         end
         if (wr_hit(wr_acc, idx, `SHSQ_IDX_IRQ_EN)) begin
            irq_en_q <= i_avs_writedata[`SHSQ_IRQ_W-1:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // operation tracking
   // ----------------------------------------------------------------
   // start wins over end in the same cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         active_q <= 1'b0;
         kind_q   <= shsq_pkg::SHSQ_OP_OTHER;
      end else if (i_ce) begin
         if (i_op_start) begin
            active_q <= 1'b1;
            kind_q   <= i_op_kind;
         end else if (i_op_end) begin
            active_q <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // header voting
   // ----------------------------------------------------------------
   // a copy arriving with the sector start counts for the new sector
   always_comb begin
      cnt_d   = cnt_q;
      seen_d  = seen_q;
      done_d  = done_q;
      go_d    = 1'b0;
      thr_err = 1'b0;
      good    = active_q && i_copy.valid && i_copy.am_found && i_copy.crc_good;
      if (active_q && i_sector_start) begin
         cnt_d  = 2'h0;
         seen_d = 1'b0;
         done_d = 1'b0;
         if (need_copies(kind_q, vote) == 2'h0) begin
            done_d = 1'b1;
            go_d   = 1'b1;
         end
      end
      if (good && i_copy.match && !done_d) begin
         seen_d = 1'b1;
         cnt_d  = cnt_d + 2'h1;
         if (cnt_d >= need_copies(kind_q, vote)) begin
            done_d = 1'b1;
            go_d   = 1'b1;
         end
      end
      // vote missed: a good matching copy was seen but not enough of them
      if (active_q && i_hdr_end && !i_sector_start && seen_q && !done_q) begin
         thr_err = (kind_q == shsq_pkg::SHSQ_OP_OTHER);
      end
   end
   // voting state and the go pulse
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         cnt_q  <= 2'h0;
         seen_q <= 1'b0;
         done_q <= 1'b0;
         go_q   <= 1'b0;
      end else if (i_ce) begin
         cnt_q  <= cnt_d;
         seen_q <= seen_d;
         done_q <= done_d;
         go_q   <= go_d;
      end
   end

   // ----------------------------------------------------------------
   // header error status
   // ----------------------------------------------------------------
   // copies after the vote still update flags; only needed ones are trusted
   always_comb begin
      stat_d   = stat_q;
      copy_bit = 3'h1 << i_copy.idx; // idx 3 maps to no flag
      if (active_q && i_sector_start) begin
         stat_d[`SHSQ_ST_THR_ERR] = 1'b0;
         stat_d[`SHSQ_ST_BEYOND]  = 1'b0;
         stat_d[5:0]              = `SHSQ_STAT_SECTOR;
      end
      if (active_q && i_copy.valid && i_copy.am_found) begin
         stat_d[2:0] = stat_d[2:0] & ~copy_bit;
         if (i_copy.crc_good) begin
            stat_d[5:3] = stat_d[5:3] & ~copy_bit;
         end
      end
      if (good && i_copy.greater) begin
         stat_d[`SHSQ_ST_BEYOND] = 1'b1;
      end
      if (thr_err) begin
         stat_d[`SHSQ_ST_THR_ERR] = 1'b1;
      end
   end
   // no bus write path reaches this register
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         stat_q <= `SHSQ_STAT_RESET;
      end else if (i_ce) begin
         stat_q <= stat_d;
      end
   end

   // ----------------------------------------------------------------
   // data sync qualification
   // ----------------------------------------------------------------
   // thresholds above 12 are stored but can never be met by the channel
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         found_q <= 1'b0;
      end else if (i_ce) begin
         found_q <= active_q && i_sync_eval && !skip_mode
                    && (i_sync_groups >= sthr);
      end
   end

   // ----------------------------------------------------------------
   // skip mode sequencer
   // ----------------------------------------------------------------
   // no back-pressure: the byte stream runs one byte per enabled cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         sk_q     <= shsq_pkg::SHSQ_SK_IDLE;
         sk_cnt_q <= 8'h0;
         bv_q     <= 1'b0;
         bd_q     <= 8'h0;
         hunt_q   <= 1'b0;
      end else if (i_ce) begin
         case (sk_q)
            shsq_pkg::SHSQ_SK_IDLE: begin
               hunt_q <= 1'b0;
               bv_q   <= 1'b0;
               if (active_q && i_data_start && skip_mode) begin
                  sk_q     <= shsq_pkg::SHSQ_SK_SYNC;
                  bv_q     <= 1'b1;
                  bd_q     <= `SHSQ_SYNC_BYTE;
                  sk_cnt_q <= dummy_total(skip_q[`SHSQ_SKIP_MSB:`SHSQ_SKIP_LSB]);
               end
            end
            shsq_pkg::SHSQ_SK_SYNC,
            shsq_pkg::SHSQ_SK_DUMMY: begin
               if (sk_cnt_q == 8'h0) begin
                  sk_q   <= shsq_pkg::SHSQ_SK_HUNT;
                  bv_q   <= 1'b0;
                  hunt_q <= 1'b1;
               end else begin
                  sk_q     <= shsq_pkg::SHSQ_SK_DUMMY;
                  bv_q     <= 1'b1;
                  bd_q     <= `SHSQ_DUMMY_BYTE;
                  sk_cnt_q <= sk_cnt_q - 8'h1;
               end
            end
            shsq_pkg::SHSQ_SK_HUNT: begin
               hunt_q <= 1'b0;
               sk_q   <= shsq_pkg::SHSQ_SK_IDLE;
            end
            default: begin
               sk_q   <= shsq_pkg::SHSQ_SK_IDLE;
               bv_q   <= 1'b0;
               hunt_q <= 1'b0;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // interrupts
   // ----------------------------------------------------------------
   // events: go, threshold error, beyond target, sync found, skip done
   assign irq_ev = {hunt_q, found_q, good && i_copy.greater, thr_err, go_q};

   // set wins over a clear in the same cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_st_q <= '0;
      end else if (i_ce) begin
         irq_st_q <= (irq_st_q & ~(wr_hit(wr_acc, idx, `SHSQ_IDX_IRQ_CLR) ?
                      i_avs_writedata[`SHSQ_IRQ_W-1:0] : '0)) | irq_ev;
      end
   end

   // registered so the pin is glitch free; lags status by one cycle
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         irq_q <= 1'b0;
      end else if (i_ce) begin
         irq_q <= |(irq_st_q & irq_en_q);
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign o_avs_readdata    = rdata_q;
   assign o_avs_waitrequest = wait_q;
   assign o_op_active       = active_q;
   assign o_sector_go       = go_q;
   assign o_sync_found      = found_q;
   assign o_byte_valid      = bv_q;
   assign o_byte_data       = bd_q;
   assign o_resync_hunt     = hunt_q;
   assign o_irq             = irq_q;

endmodule : shsq_top

// *** logic/shsq_params.svh ***
// offsets, field positions, reset values and constants of the header/sync qualifier
`ifndef SHSQ_PARAMS_SVH
`define SHSQ_PARAMS_SVH
// ----------------------------------------------------------------
// register indexes (byte address = 4 * index)
// ----------------------------------------------------------------
`define SHSQ_IDX_SKIP      7'h25
`define SHSQ_IDX_CTRL      7'h26
`define SHSQ_IDX_STAT      7'h27
`define SHSQ_IDX_IRQ_STAT  7'h40
`define SHSQ_IDX_IRQ_CLR   7'h41
`define SHSQ_IDX_IRQ_EN    7'h42
// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SHSQ_VOTE_MSB      5
`define SHSQ_VOTE_LSB      4
`define SHSQ_STHR_MSB      3
`define SHSQ_STHR_LSB      0
`define SHSQ_SKIP_MSB      5
`define SHSQ_SKIP_LSB      4
`define SHSQ_ST_THR_ERR    7
`define SHSQ_ST_BEYOND     6
`define SHSQ_ST_CRC_LSB    3
`define SHSQ_ST_AM_LSB     0
// ----------------------------------------------------------------
// reset values and stream constants
// ----------------------------------------------------------------
`define SHSQ_CTRL_RESET    8'h19
`define SHSQ_SKIP_RESET    8'h00
`define SHSQ_STAT_RESET    8'h00
`define SHSQ_STAT_SECTOR   6'h3f
`define SHSQ_SYNC_BYTE     8'h0d
`define SHSQ_DUMMY_BYTE    8'h00
`define SHSQ_DUMMY_PER_MK  8'h28
`define SHSQ_IRQ_W         5
`endif

// *** logic/shsq_pkg.sv ***
// types shared by the header/sync qualifier
package shsq_pkg;
   // ----------------------------------------------------------------
   // operation kinds
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SHSQ_OP_OTHER  = 2'h0,
      SHSQ_OP_LOCATE = 2'h1,
      SHSQ_OP_FETCH  = 2'h2
   } shsq_op_e;
   // ----------------------------------------------------------------
   // one header copy as reported by the read channel
   // ----------------------------------------------------------------
   typedef struct packed {
      logic       valid;
      logic [1:0] idx;
      logic       am_found;
      logic       crc_good;
      logic       match;
      logic       greater;
   } shsq_copy_s;
   // ----------------------------------------------------------------
   // skip sequencer states, gray along the path except the SYNC to HUNT step at skip count 0
   // ----------------------------------------------------------------
   typedef enum logic [1:0] {
      SHSQ_SK_IDLE  = 2'h0,
      SHSQ_SK_SYNC  = 2'h1,
      SHSQ_SK_DUMMY = 2'h3,
      SHSQ_SK_HUNT  = 2'h2
   } shsq_skip_e;
endpackage : shsq_pkg

// *** bench/shsq_chan_model.sv ***
// read channel model: sector, header copy, data and sync events
`timescale 1ns/10ps
module shsq_chan_model (
   input  wire logic            i_clk,
   output shsq_pkg::shsq_copy_s o_copy,
   output logic                 o_sector_start,
   output logic                 o_hdr_end,
   output logic                 o_data_start,
   output logic                 o_sync_eval,
   output logic [3:0]           o_sync_groups
);
   // quiet lines at time zero
   initial begin
      o_copy = '0;
      o_sector_start = 1'b0;
      o_hdr_end = 1'b0;
      o_data_start = 1'b0;
      o_sync_eval = 1'b0;
      o_sync_groups = 4'h0;
   end
   // one sector: start, three copies, end of header area
   task sector(input logic [2:0] am, cr, mt, gt);
      @(posedge i_clk);
      o_sector_start <= 1'b1;
      for (int i = 0; i < 3; i++) begin
         @(posedge i_clk);
         o_sector_start <= 1'b0;
         o_copy <= {1'b1, 2'(i), am[i], cr[i], mt[i], gt[i]};
      end
      @(posedge i_clk);
      o_copy <= {1'b0, 6'($urandom)}; // scrambled, stale fields must not count
      o_hdr_end <= 1'b1;
      @(posedge i_clk);
      o_hdr_end <= 1'b0;
   endtask : sector
   // one sync evaluation; groups inverted afterwards
   task sync(input logic [3:0] g);
      @(posedge i_clk);
      o_sync_eval <= 1'b1;
      o_sync_groups <= g;
      @(posedge i_clk);
      o_sync_eval <= 1'b0;
      o_sync_groups <= ~g;
   endtask : sync
   // data field begins
   task data();
      @(posedge i_clk);
      o_data_start <= 1'b1;
      @(posedge i_clk);
      o_data_start <= 1'b0;
   endtask : data
endmodule : shsq_chan_model

// *** bench/shsq_top_sva.sv ***
// concurrent checks on the qualifier ports
`timescale 1ns/10ps
`include "shsq_params.svh"
module shsq_top_sva (
   input wire logic                 i_clk,
   input wire logic                 i_resetn,
   input wire logic [8:0]           i_avs_address,
   input wire logic                 i_avs_read,
   input wire logic                 i_avs_write,
   input wire logic [31:0]          i_avs_writedata,
   input wire logic                 o_avs_waitrequest,
   input wire logic                 i_op_start,
   input wire shsq_pkg::shsq_op_e   i_op_kind,
   input wire logic                 i_sector_start,
   input wire shsq_pkg::shsq_copy_s i_copy,
   input wire logic                 i_data_start,
   input wire logic                 i_sync_eval,
   input wire logic [3:0]           i_sync_groups,
   input wire logic                 o_op_active,
   input wire logic                 o_sector_go,
   input wire logic                 o_sync_found,
   input wire logic                 o_byte_valid,
   input wire logic [7:0]           o_byte_data,
   input wire logic                 o_resync_hunt
);
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_resetn);
   logic [7:0] ctrl_q, skip_q;
   logic       oth_q;
   logic [1:0] n_q, need, n_eff;
   logic [6:0] dum_q;
   logic       good, go_cause;
   // -----------------------------
   // shadow of control registers
   // -----------------------------
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         ctrl_q <= `SHSQ_CTRL_RESET;
         skip_q <= `SHSQ_SKIP_RESET;
      end else if (i_avs_write && !o_avs_waitrequest) begin
         if (i_avs_address[8:2] == `SHSQ_IDX_CTRL) ctrl_q <= i_avs_writedata[7:0];
         if (i_avs_address[8:2] == `SHSQ_IDX_SKIP) skip_q <= i_avs_writedata[7:0];
      end
   end
   // operation kind and good copies seen this sector
   assign need = oth_q ? ctrl_q[5:4] : 2'h1;
   assign n_eff = i_sector_start ? 2'h0 : n_q;
   assign good = o_op_active && i_copy.valid && i_copy.am_found && i_copy.crc_good
                 && i_copy.match;
   assign go_cause = o_op_active && ((i_sector_start && need == 2'h0)
                     || (good && {1'b0, n_eff} + 3'h1 == {1'b0, need}));
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         oth_q <= 1'b1;
         n_q <= 2'h0;
      end else begin
         if (i_op_start) oth_q <= (i_op_kind == shsq_pkg::SHSQ_OP_OTHER);
         if (o_op_active) n_q <= good && n_eff != 2'h3 ? n_eff + 2'h1 : n_eff;
      end
   end
   // dummy bytes since the substitute sync byte
   always_ff @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) dum_q <= 7'h00;
      else if (o_byte_valid) dum_q <= (o_byte_data == `SHSQ_SYNC_BYTE) ? 7'h00 : dum_q + 7'h01;
   end
   // -----------------------------
   // assertions
   // -----------------------------
   a_bus_answer: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
      |=> !o_avs_waitrequest) else $error("bus request not answered next cycle");
   a_bus_one_cycle: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   a_go_has_cause: assert property (o_sector_go |-> $past(go_cause))
      else $error("sector go without enough good copies");
   a_go_when_due: assert property (go_cause |=> o_sector_go)
      else $error("sector go missing");
   a_sync_accept: assert property (i_sync_eval && o_op_active && ctrl_q[3:0] != 4'h0
      |=> o_sync_found == ($past(i_sync_groups) >= ctrl_q[3:0])) else $error("sync decision wrong");
   a_skip_no_sync: assert property (i_sync_eval && ctrl_q[3:0] == 4'h0 |=> !o_sync_found)
      else $error("sync found in skip mode");
   a_skip_sync_byte: assert property (i_data_start && o_op_active && ctrl_q[3:0] == 4'h0
      && !o_byte_valid && !o_resync_hunt |=> o_byte_valid && o_byte_data == `SHSQ_SYNC_BYTE)
      else $error("substitute sync byte missing");
   a_dummy_value: assert property (o_byte_valid && o_byte_data != `SHSQ_SYNC_BYTE
      |-> o_byte_data == `SHSQ_DUMMY_BYTE) else $error("dummy byte value wrong");
   a_dummy_count: assert property (o_resync_hunt |-> !o_byte_valid
      && dum_q == skip_q[5:4] * 7'(`SHSQ_DUMMY_PER_MK)) else $error("dummy byte count wrong");
   c_go: cover property (o_sector_go);
   c_found: cover property (o_sync_found);
   c_hunt: cover property (o_resync_hunt && skip_q[5:4] == 2'h3);
endmodule : shsq_top_sva
bind shsq_top shsq_top_sva u_sva (.*);

// *** bench/tb_shsq_top.sv ***
// self-checking bench for the header/sync qualifier
`timescale 1ns/10ps
`include "shsq_params.svh"
module tb_shsq_top;
   logic i_clk = 1'b0, i_resetn = 1'b0, rd = 1'b0, wrs = 1'b0, op_s = 1'b0, op_e = 1'b0;
   logic [8:0] adr = 9'h000;
   logic [31:0] wd = 32'h0, rdata;
   shsq_pkg::shsq_op_e kind = shsq_pkg::SHSQ_OP_OTHER;
   shsq_pkg::shsq_copy_s cp;
   logic ss, he, ds, se, wt, act, go, fnd, bv, hunt, irq;
   logic [3:0] sg;
   logic [7:0] bd;
   int miscompares = 0, checks = 0, n_go = 0, n_found = 0, n_sync = 0, n_dum = 0, n_hunt = 0;
   always #5 i_clk = ~i_clk;
   shsq_chan_model u_chan (.i_clk(i_clk), .o_copy(cp), .o_sector_start(ss), .o_hdr_end(he),
      .o_data_start(ds), .o_sync_eval(se), .o_sync_groups(sg));
   shsq_top dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ce(1'b1), .i_avs_address(adr),
      .i_avs_read(rd), .i_avs_write(wrs), .i_avs_writedata(wd), .o_avs_readdata(rdata),
      .o_avs_waitrequest(wt), .i_op_start(op_s), .i_op_kind(kind), .i_op_end(op_e),
      .i_sector_start(ss), .i_copy(cp), .i_hdr_end(he), .i_data_start(ds), .i_sync_eval(se),
      .i_sync_groups(sg), .o_op_active(act), .o_sector_go(go), .o_sync_found(fnd),
      .o_byte_valid(bv), .o_byte_data(bd), .o_resync_hunt(hunt), .o_irq(irq));
   // ---------------------------
   // event counters
   // ---------------------------
   always @(posedge i_clk) begin
      n_go += (go === 1'b1);
      n_found += (fnd === 1'b1);
      n_hunt += (hunt === 1'b1);
      n_sync += (bv === 1'b1 && bd === `SHSQ_SYNC_BYTE);
      n_dum += (bv === 1'b1 && bd === `SHSQ_DUMMY_BYTE);
   end
   task final_report();
      if (miscompares == 0 && checks > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask : final_report
   task chk(input logic [31:0] seen, input logic [31:0] exp);
      checks++;
      if (seen !== exp) begin
         miscompares++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // avalon access: hold until waitrequest sampled low
   task bus(input logic w, input logic [6:0] ix, input logic [7:0] d, output logic [31:0] q);
      int n;
      @(posedge i_clk);
      adr <= {ix, 2'b00};
      rd <= !w;
      wrs <= w;
      wd <= {24'h0, d};
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (wt !== 1'b0 && n < 20);
      q = rdata;
      rd <= 1'b0;
      wrs <= 1'b0;
      if (n >= 20) begin
         miscompares++;
         $display("BAD %0t bus access never answered", $time);
      end
   endtask : bus
   task wr(input logic [6:0] ix, input logic [7:0] d);
      logic [31:0] q;
      bus(1'b1, ix, d, q);
   endtask : wr
   task rdchk(input logic [6:0] ix, input logic [7:0] e);
      logic [31:0] q;
      bus(1'b0, ix, 8'h00, q);
      chk(q, {24'h0, e});
   endtask : rdchk
   // end any running operation, then start a new one
   task op(input shsq_pkg::shsq_op_e k);
      @(posedge i_clk);
      op_e <= 1'b1;
      @(posedge i_clk);
      op_e <= 1'b0;
      op_s <= 1'b1;
      kind <= k;
      @(posedge i_clk);
      op_s <= 1'b0;
      chk(act, 1'b0);
   endtask : op
   // expected header status after one sector
   function automatic logic [7:0] exp_stat(input logic [2:0] am, cr, mt, gt,
                                           input logic oth, input logic [1:0] need);
      logic [2:0] gd;
      gd = am & cr;
      return {oth && (gd & mt) != 3'h0 && $countones(gd & mt) < need,
              (gd & gt) != 3'h0, ~gd, ~am};
   endfunction : exp_stat
   // hang guard, well above the expected run
   initial begin
      repeat (20000) @(posedge i_clk);
      miscompares++;
      final_report();
   end
   initial begin
      logic [2:0] am, cr, mt, gt;
      logic [1:0] v, need;
      logic [3:0] th, g;
      logic [31:0] q;
      shsq_pkg::shsq_op_e k;
      int base, b0, b1, b2;
      void'($urandom(94));
      repeat (2) @(posedge i_clk);
      i_resetn <= 1'b1;
      rdchk(`SHSQ_IDX_CTRL, `SHSQ_CTRL_RESET);
      rdchk(`SHSQ_IDX_SKIP, `SHSQ_SKIP_RESET);
      rdchk(`SHSQ_IDX_STAT, `SHSQ_STAT_RESET);
      rdchk(`SHSQ_IDX_IRQ_EN, 8'h00);
      rdchk(7'h7f, 8'h00);
      wr(7'h7f, 8'hff);
      wr(`SHSQ_IDX_STAT, 8'hff);
      rdchk(`SHSQ_IDX_STAT, `SHSQ_STAT_RESET);
      wr(`SHSQ_IDX_IRQ_EN, 8'h01);
      // every op kind with every vote code, then random mixes
      for (int r = 0; r < 24; r++) begin
         k = shsq_pkg::shsq_op_e'((r < 12) ? r / 4 : $urandom_range(2));
         v = (r < 12) ? 2'(r % 4) : 2'($urandom);
         need = (k == shsq_pkg::SHSQ_OP_OTHER) ? v : 2'h1;
         wr(`SHSQ_IDX_CTRL, {2'b00, v, 4'h9});
         op(k);
         for (int s = 0; s < 2; s++) begin
            {am, cr, mt, gt} = 12'($urandom);
            if (r < 12 && s == 0) {am, cr, mt} = 9'h1ff;
            base = n_go;
            u_chan.sector(am, cr, mt, gt);
            repeat (2) @(posedge i_clk);
            rdchk(`SHSQ_IDX_STAT, exp_stat(am, cr, mt, gt, k == 0, need));
            rdchk(`SHSQ_IDX_STAT, exp_stat(am, cr, mt, gt, k == 0, need));
            chk(act, 1'b1);
            chk(n_go - base, need == 2'h0 || $countones(am & cr & mt) >= need);
         end
      end
      // interrupt raised, masked, cleared
      chk(irq, 1'b1);
      bus(1'b0, `SHSQ_IDX_IRQ_STAT, 8'h00, q);
      chk(q[0], 1'b1);
      wr(`SHSQ_IDX_IRQ_EN, 8'h00);
      repeat (2) @(posedge i_clk);
      chk(irq, 1'b0);
      wr(`SHSQ_IDX_IRQ_CLR, 8'h1f);
      rdchk(`SHSQ_IDX_IRQ_STAT, 8'h00);
      wr(`SHSQ_IDX_IRQ_EN, 8'h1f);
      // sync threshold with boundary cases first
      op(shsq_pkg::SHSQ_OP_OTHER);
      for (int r = 0; r < 16; r++) begin
         th = (r < 2) ? 4'hc : 4'($urandom_range(12, 1));
         g = (r < 2) ? 4'hc - 4'(r) : 4'($urandom);
         wr(`SHSQ_IDX_CTRL, {4'h1, th});
         base = n_found;
         u_chan.sync(g);
         repeat (2) @(posedge i_clk);
         chk(n_found - base, g >= th);
      end
      // skip mode for every skip count
      for (int s = 0; s < 4; s++) begin
         wr(`SHSQ_IDX_SKIP, {2'b00, 2'(s), 4'h0});
         wr(`SHSQ_IDX_CTRL, 8'h10);
         base = n_found;
         b0 = n_sync;
         b1 = n_dum;
         b2 = n_hunt;
         u_chan.sync(4'hf);
         u_chan.data();
         repeat (40 * s + 4) @(posedge i_clk);
         chk(n_found - base, 0);
         chk(n_sync - b0, 1);
         chk(n_dum - b1, s * `SHSQ_DUMMY_PER_MK);
         chk(n_hunt - b2, 1);
      end
      chk(irq, 1'b1);
      final_report();
   end
endmodule : tb_shsq_top
